//--- char_buffer.sv
`timescale 1ns/10ps
module char_buffer #(
   parameter int W     = 8,
   parameter int DEPTH = sensor_pkg::BUF_DEPTH
) (
   input  wire logic clock_in,
   input  wire logic srst_in,
   stream_if.snk     fill,
   stream_if.src     drain
);
   import sensor_pkg::*;
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [W-1:0] mem_next [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0]   cnt_reg, cnt_next;
   logic          push, pop;

   assign fill.ready  = (cnt_reg != (PW+1)'(DEPTH));
   assign drain.valid = (cnt_reg != '0);
   assign drain.data  = mem_reg[rd_reg];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_comb begin
      mem_next = mem_reg;
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = fill.data;
         wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + PW'(1);
      end
      if (pop) begin
         rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + PW'(1);
      end
      if (push && !pop) cnt_next = cnt_reg + (PW+1)'(1);
      else if (pop && !push) cnt_next = cnt_reg - (PW+1)'(1);
   end

   always_ff @(posedge clock_in) begin
      mem_reg <= mem_next;
      if (srst_in) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   no_word_lost_a: assert property (@(posedge clock_in) disable iff (srst_in)
      (cnt_reg == (PW+1)'(DEPTH) && !drain.ready) |=> (cnt_reg == (PW+1)'(DEPTH)))
      else $error("buffer lost a word while full");
endmodule : char_buffer

//--- dual_period_sensor_readout.sv
// Summary of operation
// - two frequency inputs, pressure and internal temperature, feed the period measurement.
// - a sampling command first routes its required input to the counter, then measures.
// - the counter counts 14.74 MHz timebase ticks across the integration interval.
// - a command needing both signals measures temperature fully before pressure.
// - integration time is set in steps of about 3 ms, from 3 ms to 45 s.
// - the resolution setting offers 15000 steps.
// - the reply is built and sent only after the period measurement has finished.
// - the serial rate is programmable from 300 to 19200 baud, same rate at both ends.
// - characters carry 8 data bits, no parity and one stop bit.
// - result rate is bounded by integration time, up to 50/s normal and 135/s burst.
// - a command line is asterisk, two destination digits, two source digits, two-character code, CR, LF.
// - only commands for our own address or broadcast 99 are acted on.
// - a new command aborts the current one; unknown commands are discarded.
`timescale 1ns/10ps
module dual_period_sensor_readout #(
   parameter int STEP_CYC = sensor_pkg::STEP_CYCLES,
   parameter int CLK_FREQ = sensor_pkg::CLK_HZ
) (
   input  wire logic                          clock_in,
   input  wire logic                          srst_in,
   input  wire logic                          rx_in,
   input  wire logic                          temp_freq_in,
   input  wire logic                          press_freq_in,
   input  wire logic                          timebase_tick_in,
   input  wire logic [sensor_pkg::ADDR_W-1:0] own_addr_in,
   input  wire logic [sensor_pkg::RES_W-1:0]  resolution_in,
   input  wire logic [sensor_pkg::DIV_W-1:0]  baud_div_in,
   output logic                               tx_out,
   output logic                               busy_out
);
   import sensor_pkg::*;
   // bit-time limits follow the clock, so a slow-clock build keeps the same 300..19200 baud span
   localparam int DIV_LO = CLK_FREQ / BAUD_MAX;
   localparam int DIV_HI = CLK_FREQ / BAUD_MIN;

   stream_if #(.W(DATA_BITS)) fill_if ();
   stream_if #(.W(DATA_BITS)) drain_if ();

   logic [DIV_W-1:0]  div_eff;
   logic [RES_W-1:0]  res_eff;
   logic [GATE_W-1:0] gate_len;
   assign div_eff  = DIV_W'(clamp_u(32'(baud_div_in), DIV_LO, DIV_HI));
   assign res_eff  = RES_W'(clamp_u(32'(resolution_in), RES_MIN, RES_MAX));
   assign gate_len = GATE_W'(res_eff) * GATE_W'(STEP_CYC);

   // receiver: mid-bit sampling, frames with a bad stop bit are dropped
   logic             rx_busy_reg, rx_busy_next, rx_valid_reg, rx_valid_next;
   logic [DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
   logic [3:0]       rx_bit_reg, rx_bit_next;
   logic [7:0]       rx_sh_reg, rx_sh_next;

   always_comb begin
      rx_busy_next  = rx_busy_reg;
      rx_cnt_next   = rx_cnt_reg;
      rx_bit_next   = rx_bit_reg;
      rx_sh_next    = rx_sh_reg;
      rx_valid_next = 1'b0;
      if (!rx_busy_reg) begin
         if (!rx_in) begin
            rx_busy_next = 1'b1;
            rx_cnt_next  = div_eff >> 1;
            rx_bit_next  = 4'h0;
         end
      end else if (rx_cnt_reg != '0) begin
         rx_cnt_next = rx_cnt_reg - DIV_W'(1);
      end else begin
         rx_cnt_next = div_eff - DIV_W'(1);
         rx_bit_next = rx_bit_reg + 4'h1;
         if (rx_bit_reg == 4'h0) begin
            if (rx_in) rx_busy_next = 1'b0;
         end else if (rx_bit_reg <= 4'h8) begin
            rx_sh_next = {rx_in, rx_sh_reg[7:1]};
         end else begin
            rx_busy_next  = 1'b0;
            rx_valid_next = rx_in;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rx_busy_reg  <= 1'b0;
         rx_cnt_reg   <= '0;
         rx_bit_reg   <= 4'h0;
         rx_sh_reg    <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_busy_reg  <= rx_busy_next;
         rx_cnt_reg   <= rx_cnt_next;
         rx_bit_reg   <= rx_bit_next;
         rx_sh_reg    <= rx_sh_next;
         rx_valid_reg <= rx_valid_next;
      end
   end

   // command line parser; an asterisk anywhere restarts the line
   parse_e           ps_reg, ps_next;
   logic [ADDR_W-1:0] dest_reg, dest_next;
   logic [7:0]       c1_reg, c1_next, c2_reg, c2_next;
   logic             cmd_valid_reg, cmd_valid_next;
   cmd_e             cmd_reg, cmd_next, cmd_dec;
   logic [3:0]       dval;
   assign dval = rx_sh_reg[3:0];

   always_comb begin
      cmd_dec = CMD_NONE;
      if (c1_reg == CH_P && c2_reg == CH_ONE) cmd_dec = CMD_PPER;
      else if (c1_reg == CH_Q && c2_reg == CH_ONE) cmd_dec = CMD_TPER;
      else if (c1_reg == CH_P && c2_reg == CH_THREE) cmd_dec = CMD_BOTH;
   end

   always_comb begin
      ps_next        = ps_reg;
      dest_next      = dest_reg;
      c1_next        = c1_reg;
      c2_next        = c2_reg;
      cmd_next       = cmd_reg;
      cmd_valid_next = 1'b0;
      if (rx_valid_reg) begin
         if (rx_sh_reg == CH_STAR) begin
            ps_next = PS_D1;
         end else begin
            case (ps_reg)
               PS_D1: begin
                  dest_next = ADDR_W'(dval) * 7'h0A;
                  ps_next   = is_digit(rx_sh_reg) ? PS_D2 : PS_IDLE;
               end
               PS_D2: begin
                  dest_next = dest_reg + ADDR_W'(dval);
                  ps_next   = is_digit(rx_sh_reg) ? PS_S1 : PS_IDLE;
               end
               PS_S1: ps_next = is_digit(rx_sh_reg) ? PS_S2 : PS_IDLE;
               PS_S2: ps_next = is_digit(rx_sh_reg) ? PS_C1 : PS_IDLE;
               PS_C1: begin
                  c1_next = rx_sh_reg;
                  ps_next = PS_C2;
               end
               PS_C2: begin
                  c2_next = rx_sh_reg;
                  ps_next = PS_CR;
               end
               PS_CR: if (rx_sh_reg == CH_CR) ps_next = PS_LF;
               PS_LF: begin
                  ps_next = PS_IDLE;
                  if (rx_sh_reg == CH_LF && cmd_dec != CMD_NONE &&
                      (dest_reg == own_addr_in || dest_reg == BCAST_ADDR)) begin
                     cmd_valid_next = 1'b1;
                     cmd_next       = cmd_dec;
                  end
               end
               default: ps_next = PS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ps_reg        <= PS_IDLE;
         dest_reg      <= '0;
         c1_reg        <= 8'h00;
         c2_reg        <= 8'h00;
         cmd_reg       <= CMD_NONE;
         cmd_valid_reg <= 1'b0;
      end else begin
         ps_reg        <= ps_next;
         dest_reg      <= dest_next;
         c1_reg        <= c1_next;
         c2_reg        <= c2_next;
         cmd_reg       <= cmd_next;
         cmd_valid_reg <= cmd_valid_next;
      end
   end

   // period measurement over whole signal periods covering the gate
   meas_e             ms_reg, ms_next;
   logic              sel_reg, sel_next, both_reg, both_next, prev_reg, go_reg, go_next;
   logic [GATE_W-1:0] gate_reg, gate_next;
   logic [CNT_W-1:0]  tb_reg, tb_next, va_reg, va_next, vb_reg, vb_next;
   logic              sig, rise, busy_next;
   assign sig  = (sel_reg == SEL_PRESS) ? press_freq_in : temp_freq_in;
   assign rise = sig & ~prev_reg;

   always_comb begin
      ms_next   = ms_reg;
      sel_next  = sel_reg;
      both_next = both_reg;
      gate_next = gate_reg;
      tb_next   = tb_reg;
      va_next   = va_reg;
      vb_next   = vb_reg;
      go_next   = 1'b0;
      if (cmd_valid_reg) begin
         both_next = (cmd_reg == CMD_BOTH);
         sel_next  = (cmd_reg == CMD_PPER) ? SEL_PRESS : SEL_TEMP;
         ms_next   = M_SEL;
      end else begin
         case (ms_reg)
            M_IDLE: ms_next = M_IDLE;
            M_SEL:  ms_next = M_ARM;
            M_ARM: if (rise) begin
               // the edge cycle opens the window, so whole periods are counted edge to edge
               ms_next   = M_RUN;
               gate_next = GATE_W'(1);
               tb_next   = CNT_W'(timebase_tick_in);
            end
            M_RUN: begin
               if (gate_reg < gate_len) gate_next = gate_reg + GATE_W'(1);
               if (timebase_tick_in) tb_next = tb_reg + CNT_W'(1);
               if (rise && gate_reg >= gate_len) begin
                  if (both_reg && sel_reg == SEL_TEMP) begin
                     va_next  = tb_reg;
                     sel_next = SEL_PRESS;
                     ms_next  = M_SEL;
                  end else begin
                     vb_next = tb_reg;
                     go_next = 1'b1;
                     ms_next = M_IDLE;
                  end
               end
            end
            default: ms_next = M_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ms_reg   <= M_IDLE;
         sel_reg  <= SEL_TEMP;
         both_reg <= 1'b0;
         prev_reg <= 1'b0;
         gate_reg <= '0;
         tb_reg   <= '0;
         va_reg   <= '0;
         vb_reg   <= '0;
         go_reg   <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         ms_reg   <= ms_next;
         sel_reg  <= sel_next;
         both_reg <= both_next;
         prev_reg <= sig;
         gate_reg <= gate_next;
         tb_reg   <= tb_next;
         va_reg   <= va_next;
         vb_reg   <= vb_next;
         go_reg   <= go_next;
         busy_out <= busy_next;
      end
   end

   // reply "*00" + own address + 8 or 16 hex digits + CR LF
   logic       rp_act_reg, rp_act_next, rp_both_reg, rp_both_next;
   logic [4:0] rp_idx_reg, rp_idx_next, rp_last, k5;
   logic [CNT_W-1:0] word;
   logic [6:0] tens;
   always_comb begin
      rp_last = rp_both_reg ? REPLY_LAST_BOTH : REPLY_LAST_ONE;
      tens    = own_addr_in / 7'h0A;
      word    = (rp_both_reg && rp_idx_reg < REPLY_HEX_B) ? va_reg : vb_reg;
      k5      = (rp_idx_reg < REPLY_HEX_B) ? rp_idx_reg - REPLY_HEX_A : rp_idx_reg - REPLY_HEX_B;
      case (rp_idx_reg)
         5'h00:   fill_if.data = CH_STAR;
         5'h01:   fill_if.data = CH_ZERO;
         5'h02:   fill_if.data = CH_ZERO;
         5'h03:   fill_if.data = CH_ZERO + {1'b0, tens};
         5'h04:   fill_if.data = CH_ZERO + {1'b0, own_addr_in - 7'(tens * 7'h0A)};
         default: fill_if.data = hex_char(4'(word >> (5'h1C - {k5[2:0], 2'b00})));
      endcase
      if (rp_idx_reg == rp_last - 5'h1) fill_if.data = CH_CR;
      if (rp_idx_reg == rp_last) fill_if.data = CH_LF;
      fill_if.valid = rp_act_reg;
      rp_act_next   = rp_act_reg;
      rp_both_next  = rp_both_reg;
      rp_idx_next   = rp_idx_reg;
      if (cmd_valid_reg) begin
         rp_act_next = 1'b0;
      end else if (go_reg) begin
         rp_act_next  = 1'b1;
         rp_both_next = both_reg;
         rp_idx_next  = 5'h00;
      end else if (rp_act_reg && fill_if.ready) begin
         rp_idx_next = rp_idx_reg + 5'h1;
         if (rp_idx_reg == rp_last) rp_act_next = 1'b0;
      end
      busy_next = (ms_next != M_IDLE) | rp_act_next;
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rp_act_reg  <= 1'b0;
         rp_both_reg <= 1'b0;
         rp_idx_reg  <= 5'h00;
      end else begin
         rp_act_reg  <= rp_act_next;
         rp_both_reg <= rp_both_next;
         rp_idx_reg  <= rp_idx_next;
      end
   end

   char_buffer #(.W(DATA_BITS), .DEPTH(BUF_DEPTH)) u_buf (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .fill     (fill_if.snk),
      .drain    (drain_if.src)
   );

   // transmitter: data line only, no handshake pins
   logic             tx_act_reg, tx_act_next, tx_next;
   logic [DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
   logic [3:0]       tx_bit_reg, tx_bit_next;
   logic [8:0]       tx_sh_reg, tx_sh_next;
   assign drain_if.ready = ~tx_act_reg;

   always_comb begin
      tx_act_next = tx_act_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_bit_next = tx_bit_reg;
      tx_sh_next  = tx_sh_reg;
      tx_next     = tx_out;
      if (!tx_act_reg) begin
         tx_next = 1'b1;
         if (drain_if.valid) begin
            tx_act_next = 1'b1;
            tx_next     = 1'b0;
            tx_sh_next  = {1'b1, drain_if.data};
            tx_cnt_next = div_eff - DIV_W'(1);
            tx_bit_next = 4'h0;
         end
      end else if (tx_cnt_reg != '0) begin
         tx_cnt_next = tx_cnt_reg - DIV_W'(1);
      end else if (tx_bit_reg == 4'h9) begin
         tx_act_next = 1'b0;
      end else begin
         tx_next     = tx_sh_reg[0];
         tx_sh_next  = {1'b1, tx_sh_reg[8:1]};
         tx_bit_next = tx_bit_reg + 4'h1;
         tx_cnt_next = div_eff - DIV_W'(1);
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tx_act_reg <= 1'b0;
         tx_cnt_reg <= '0;
         tx_bit_reg <= 4'h0;
         tx_sh_reg  <= 9'h1FF;
         tx_out     <= 1'b1;
      end else begin
         tx_act_reg <= tx_act_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_bit_reg <= tx_bit_next;
         tx_sh_reg  <= tx_sh_next;
         tx_out     <= tx_next;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);
   sequence both_cmd; cmd_valid_reg && cmd_reg == CMD_BOTH; endsequence
   sequence tx_start; !tx_act_reg && drain_if.valid; endsequence
   sequence run_tick; ms_reg == M_RUN && ms_next == M_RUN && timebase_tick_in && !cmd_valid_reg; endsequence

   mux_settle_a: assert property ((ms_reg == M_SEL && !cmd_valid_reg) |=> ms_reg == M_ARM)
      else $error("source not settled before arming");
   temp_first_a: assert property (both_cmd |=> (sel_reg == SEL_TEMP && ms_reg == M_SEL))
      else $error("pressure measured before temperature");
   reply_after_a: assert property ($rose(rp_act_reg) |-> $past(ms_reg, 2) == M_RUN)
      else $error("reply began without finished measurement");
   abort_cmd_a: assert property (cmd_valid_reg |=> (ms_reg == M_SEL && !rp_act_reg))
      else $error("new command did not abort");
   addr_match_a: assert property (cmd_valid_reg |-> (dest_reg == own_addr_in || dest_reg == BCAST_ADDR))
      else $error("command for another address accepted");
   tx_frame_a: assert property (tx_start |=> (!tx_out && tx_act_reg) ##1 !tx_out [*1])
      else $error("start bit missing");
   gate_hold_a: assert property ((ms_reg == M_RUN && gate_reg < gate_len && !cmd_valid_reg) |=> ms_reg == M_RUN)
      else $error("gate ended early");
   timebase_cnt_a: assert property (run_tick |=> tb_reg == $past(tb_reg) + CNT_W'(1))
      else $error("timebase tick not counted");
endmodule : dual_period_sensor_readout

//--- host_model.sv
`timescale 1ns/10ps
module host_model (
   input  wire logic        clock_in,
   input  wire logic [15:0] baud_div_in,
   input  wire logic        tx_in,
   output logic             rx_out
);
   logic [7:0] got[$];
   int         framing_errs = 0;

   // idle mark level; no handshake lines exist, only data
   initial rx_out = 1'b1;

   // same clocks per bit as the device is set to
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0}; // start, 8 data lsb first, no parity, one stop
      for (int i = 0; i < 10; i++) begin
         @(posedge clock_in);
         #10 rx_out = frame[i];
         repeat (baud_div_in - 1) @(posedge clock_in);
      end
   endtask : send_byte

   // caller forms the whole line, star to line feed
   task automatic send_str(input string s);
      foreach (s[i]) send_byte(s[i]);
   endtask : send_str

   initial begin : rx_loop
      logic [7:0] b;
      // falling edges see tx_in settled, away from the edge that launches it
      forever begin
         @(negedge clock_in);
         if (tx_in === 1'b0) begin
            // mid-bit sampling tolerates the one-edge detection lag
            repeat (baud_div_in / 2) @(negedge clock_in);
            if (tx_in !== 1'b0) framing_errs++;
            for (int i = 0; i < 8; i++) begin
               repeat (baud_div_in) @(negedge clock_in);
               b[i] = tx_in; // lsb first
            end
            repeat (baud_div_in) @(negedge clock_in);
            if (tx_in !== 1'b1) framing_errs++; // single stop bit
            got.push_back(b);
         end
      end
   end
endmodule : host_model

//--- sensor_pkg.sv
package sensor_pkg;
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_NS        = 100;
   localparam int STEP_NS       = 3_000_000;
   localparam int STEP_CYCLES   = STEP_NS / CLK_NS;
   localparam int TIMEBASE_KHZ  = 14_740;
   localparam int RES_W         = 14;
   localparam int RES_MIN       = 1;
   localparam int RES_MAX       = 15_000;
   localparam int GATE_W        = 30;
   localparam int CNT_W         = 32;
   localparam int BAUD_MIN      = 300;
   localparam int BAUD_MAX      = 19_200;
   localparam int DIV_W         = 16;
   localparam int BAUD_DIV_MIN  = CLK_HZ / BAUD_MAX;
   localparam int BAUD_DIV_MAX  = CLK_HZ / BAUD_MIN;
   localparam int DATA_BITS     = 8;
   localparam int ADDR_W        = 7;
   localparam int BUF_DEPTH     = 2;
   localparam logic [6:0] BCAST_ADDR = 7'h63;
   localparam logic [7:0] CH_STAR = 8'h2A;
   localparam logic [7:0] CH_CR   = 8'h0D;
   localparam logic [7:0] CH_LF   = 8'h0A;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_ONE  = 8'h31;
   localparam logic [7:0] CH_THREE = 8'h33;
   localparam logic [7:0] CH_P    = 8'h50;
   localparam logic [7:0] CH_Q    = 8'h51;
   localparam logic [4:0] REPLY_LAST_ONE  = 5'h0E;
   localparam logic [4:0] REPLY_LAST_BOTH = 5'h16;
   localparam logic [4:0] REPLY_HEX_A     = 5'h05;
   localparam logic [4:0] REPLY_HEX_B     = 5'h0D;
   localparam logic SEL_TEMP  = 1'b0;
   localparam logic SEL_PRESS = 1'b1;

   typedef enum logic [3:0] {
      PS_IDLE = 4'h0, PS_D1 = 4'h1, PS_D2 = 4'h3, PS_S1 = 4'h2, PS_S2 = 4'h6,
      PS_C1 = 4'h7, PS_C2 = 4'h5, PS_CR = 4'h4, PS_LF = 4'hC
   } parse_e;
   typedef enum logic [1:0] {M_IDLE = 2'h0, M_SEL = 2'h1, M_ARM = 2'h3, M_RUN = 2'h2} meas_e;
   typedef enum logic [1:0] {CMD_PPER = 2'h0, CMD_TPER = 2'h1, CMD_BOTH = 2'h2, CMD_NONE = 2'h3} cmd_e;

   function automatic int unsigned clamp_u(input int unsigned v, input int unsigned lo, input int unsigned hi);
      if (v < lo) return lo;
      if (v > hi) return hi;
      return v;
   endfunction : clamp_u

   function automatic logic is_digit(input logic [7:0] b);
      return (b >= CH_ZERO) && (b <= CH_NINE);
   endfunction : is_digit

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction : hex_char
endpackage : sensor_pkg

//--- stream_if.sv
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8) ();
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : stream_if

//--- tb_dual_period_sensor_readout.sv
`timescale 1ns/10ps
module tb_dual_period_sensor_readout;
   import sensor_pkg::*;
   // short step keeps gates at tens of clocks
   localparam int STEP = 20;
   // slow nominal clock lowers the bit-time floor so every reply fits the cycle budget
   localparam int SLOW_HZ = 384_000;
   logic              clock_in, srst_in, temp_freq_in, press_freq_in, timebase_tick_in;
   logic [ADDR_W-1:0] own_addr_in;
   logic [RES_W-1:0]  resolution_in;
   logic [DIV_W-1:0]  baud_div_in;
   logic              rx_line, tx_out, busy_out;
   int                fails, num_checks, seed, tper, pper, tcnt, pcnt;
   string             cmd;

   dual_period_sensor_readout #(.STEP_CYC(STEP), .CLK_FREQ(SLOW_HZ)) dual_period_sensor_readout_i (
      .clock_in(clock_in), .srst_in(srst_in), .rx_in(rx_line), .temp_freq_in(temp_freq_in),
      .press_freq_in(press_freq_in), .timebase_tick_in(timebase_tick_in), .own_addr_in(own_addr_in),
      .resolution_in(resolution_in), .baud_div_in(baud_div_in), .tx_out(tx_out), .busy_out(busy_out));

   host_model host_i (.clock_in(clock_in), .baud_div_in(baud_div_in), .tx_in(tx_out), .rx_out(rx_line));

   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   // periods are changed only while idle, so no glitch reaches a measurement
   always begin
      @(posedge clock_in);
      #10;
      tcnt = (tcnt + 1) % tper;
      pcnt = (pcnt + 1) % pper;
      temp_freq_in = (tcnt < tper / 2);
      press_freq_in = (pcnt < pper / 2);
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   // one tick per clock: count is whole periods spanning the clamped gate
   function automatic logic [31:0] per_count(input int res, input int per);
      int g;
      g = ((res < 1) ? 1 : res) * STEP;
      return ((g + per - 1) / per) * per;
   endfunction : per_count

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 10) ? 8'h30 + 8'(n) : 8'h41 + 8'(n) - 8'h0A;
   endfunction : hexc

   task automatic expect_reply(input logic [31:0] a, input logic [31:0] b, input bit both);
      logic [7:0] exp[$];
      int         n;
      exp = {CH_STAR, CH_ZERO, CH_ZERO, 8'(CH_ZERO + own_addr_in / 10), 8'(CH_ZERO + own_addr_in % 10)};
      for (int i = 7; i >= 0; i--) exp.push_back(hexc(a[i*4+:4]));
      if (both) for (int i = 7; i >= 0; i--) exp.push_back(hexc(b[i*4+:4]));
      exp.push_back(CH_CR);
      exp.push_back(CH_LF);
      for (n = 0; n < 20000 && host_i.got.size() < exp.size(); n++) @(posedge clock_in);
      if (host_i.got.size() < exp.size()) begin
         fails++;
         close_out();
      end else begin
         foreach (exp[j]) check("reply char", {24'h0, host_i.got.pop_front()}, {24'h0, exp[j]});
         check("framing", host_i.framing_errs, 0);
      end
   endtask : expect_reply

   initial begin
      seed = 32'h75FA0040;
      {fails, num_checks, tcnt, pcnt} = '0;
      tper = 7;
      pper = 9;
      srst_in = 1'b1;
      timebase_tick_in = 1'b1;
      {temp_freq_in, press_freq_in} = 2'b00;
      own_addr_in = 7'(1 + ($unsigned($random(seed)) % 98));
      resolution_in = '0;
      baud_div_in = 16'(SLOW_HZ / BAUD_MAX + ($unsigned($random(seed)) % 8));
      repeat (12) @(posedge clock_in);
      #10 srst_in = 1'b0;
      check("tx idle", {31'h0, tx_out}, 32'h1);
      // resolution zero must clamp to one step
      host_i.send_str($sformatf("*%02d00P1\r\n", own_addr_in));
      check("busy", {31'h0, busy_out}, 32'h1);
      expect_reply(per_count(0, pper), 0, 1'b0);
      // unknown code, then another destination: both dropped
      host_i.send_str($sformatf("*%02d00ZZ\r\n", own_addr_in));
      host_i.send_str($sformatf("*%02d00P1\r\n", (own_addr_in % 98) + 1));
      repeat (3000) @(posedge clock_in);
      check("busy idle", {31'h0, busy_out}, 32'h0);
      check("silent", host_i.got.size(), 0);
      for (int r = 0; r < 2; r++) begin
         #10;
         // second pass stops the timebase: clocks alone must not count
         timebase_tick_in = (r == 0);
         tper = 7 + 2 * ($unsigned($random(seed)) % 4);
         pper = 7 + 2 * ($unsigned($random(seed)) % 4);
         resolution_in = 14'(1 + ($unsigned($random(seed)) % 3));
         cmd = (r == 0) ? "*9900P3\r\n" : $sformatf("*%02d00Q1\r\n", own_addr_in);
         host_i.send_str(cmd);
         check("busy", {31'h0, busy_out}, 32'h1);
         if (r == 0) expect_reply(per_count(resolution_in, tper), per_count(resolution_in, pper), 1'b1);
         else expect_reply(timebase_tick_in ? per_count(resolution_in, tper) : 32'h0, 0, 1'b0);
      end
      close_out();
   end
endmodule : tb_dual_period_sensor_readout
